/* File: pkg/intc_pkg.sv */
// Constants and types for the interrupt vector and standby wake controller
package intc_pkg;
    // ==========================================================
    // Sizes
    localparam int N_VEC = 14;
    localparam int N_EXT = 8;
    localparam int N_P0 = 6;
    localparam int N_P5 = 8;
    localparam int N_PIN = N_EXT + N_P0 + N_P5;
    localparam int PORT_VEC = 13;
    localparam logic [3:0] STACK_FRAME_BYTES = 4'h6;
    // ==========================================================
    // Vector addresses, lowest first
    localparam logic [15:0] VEC_ADDR [N_VEC] = '{
        16'h8000, 16'h8004, 16'h8008, 16'h800c, 16'h8014, 16'h8018, 16'h801c,
        16'h8020, 16'h8024, 16'h802c, 16'h8030, 16'h8034, 16'h8038, 16'h803c};
    // Vector index reached by each external interrupt pin
    localparam logic [3:0] EXT_VEC [N_EXT] = '{
        4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hb, 4'hc};
    // Pins whose level can release full hold (pin 3 cannot)
    localparam logic [N_EXT-1:0] EXT_HOLD_WAKE = 8'hf7;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_ENABLE = 8'h00;
    localparam logic [7:0] OFS_PRIO = 8'h04;
    localparam logic [7:0] OFS_EXTMODE = 8'h08;
    localparam logic [7:0] OFS_STBY = 8'h0c;
    localparam logic [7:0] OFS_PEND = 8'h10;
    localparam logic [7:0] OFS_INSVC = 8'h14;
    localparam logic [7:0] OFS_EVT_STAT = 8'h18;
    localparam logic [7:0] OFS_EVT_CLR = 8'h1c;
    localparam logic [7:0] OFS_EVT_EN = 8'h20;
    // Reset values and event bit positions
    localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
    localparam logic [31:0] RST_PRIO = 32'h0000_0000;
    localparam logic [31:0] RST_EXTMODE = 32'h0000_0000;
    localparam logic [1:0] RST_EVT_EN = 2'h0;
    localparam int EVT_WAKE = 0;
    localparam int EVT_ACCEPT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // Pin detection modes and standby modes
    typedef enum logic [2:0] {
        DET_HIGH = 3'h0, DET_LOW = 3'h1, DET_RISE = 3'h2, DET_FALL = 3'h3, DET_BOTH = 3'h4
    } det_mode_e;
    typedef enum logic [1:0] {
        ST_RUN = 2'h0, ST_HALT = 2'h1, ST_HOLD_WITH_SLOW_CLOCK = 2'h3, ST_HOLD = 2'h2
    } stby_e;
    // Peripheral events that may release a standby mode
    typedef struct packed {
        logic sync_serial;
        logic async_serial;
        logic base_timer;
        logic ir_rx;
        logic rtc;
    } wake_src_s;
    // Clock and execution stop controls
    typedef struct packed {
        logic cpu_stop;
        logic periph_stop;
        logic fast_osc_stop;
        logic slow_osc_stop;
    } stop_ctl_s;
endpackage

/* File: rtl/intc_standby_wake.sv */
// Interrupt vector arbitration with standby and wake control, AXI4-Lite registers
//
// Operation
// [RULE1] Pin 2, first capture timer and serial_async_b share vector 08018H.
// [RULE2] Pin 3, second capture timer and both two-wire units share vector 0801CH.
// [RULE3] Port 0, port 5, clock and checksum events share vector 0803CH.
// [RULE4] Each vector takes one of three priority levels used in arbitration.
// [RULE5] Among equal levels the lowest vector address wins.
// [RULE6] A request at or below the level in service is not accepted.
// [RULE7] A higher level wins over any address order.
// [RULE8] Entry through a vector pushes status word and return address, six bytes.
// [RULE9] Halt stops execution, peripherals run, no oscillator stops.
// [RULE10] Halt ends on reset or on any interrupt request.
// [RULE11] Full hold stops execution, peripherals and all three oscillators.
// [RULE12] Full hold ends on reset, pin level, port 0/5, sync or async serial.
// [RULE13] Slow-clock hold stops the fast oscillators and keeps the slow one.
// [RULE14] Slow-clock hold also ends on base timer, infrared and clock events.
// [RULE15] Each external pin detects high, low, rising, falling or both edges.
// [RULE16] The six low port 0 pins act as interrupt and hold-release inputs.
// [RULE17] A request stays pending until taken or cleared; its vector goes out on accept.
`timescale 1ns/10ps
`default_nettype none
module intc_standby_wake import intc_pkg::*; #(
    parameter int N_VEC_P = N_VEC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // On-chip request pulses, one bit per vector
    input wire logic [N_VEC_P-1:0] periph_req,
    input wire wake_src_s wake_src,
    // Pins: external interrupts, port 0 low pins, port 5
    input wire logic [N_EXT-1:0] ext_irq_pin,
    input wire logic [N_P0-1:0] port0_pin,
    input wire logic [N_P5-1:0] port5_pin,
    // Core side
    input wire logic irq_ack,
    input wire logic irq_done,
    output logic irq_req,
    output logic [15:0] irq_vector,
    output logic [3:0] stack_push_bytes,
    output stop_ctl_s stop_ctl,
    output logic sys_irq
);
    // ==========================================================
    // Elaboration check
    if (N_VEC_P != N_VEC) begin : g_bad_vec
        $error("vector count must match the address table");
    end

    function automatic logic [1:0] lvl_of(input logic [1:0] p);
        lvl_of = (p == 2'h3) ? 2'h3 : p + 2'h1;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            merge[8*b+:8] = s[b] ? n[8*b+:8] : o[8*b+:8];
        end
    endfunction

    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_wr, wr_hit;
    logic [31:0] enable_q, prio_q, extmode_q;
    logic [N_VEC-1:0] pend_q, set_vec, cand;
    logic [2:0] in_svc_q;
    logic [1:0] evt_stat_q, evt_en_q, evt_set;
    stby_e state_q;
    logic [N_PIN-1:0] s1_q, s2_q, s3_q, pin_q, pin_prev_q;
    logic [N_EXT-1:0] ext_det;
    logic port_evt;
    logic [3:0] irq_idx_q;
    logic [1:0] irq_lvl_q;
    logic win_valid;
    logic [3:0] win_idx;
    logic [1:0] win_lvl, cur_lvl;
    logic take, wake6, wake9, leave;

    // ==========================================================
    // AXI write channel: address and data taken in either order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Both halves held and no response waiting
    assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_hit = (awaddr_q[1:0] == 2'h0) && (awaddr_q <= OFS_EVT_EN);

    // ==========================================================
    // AXI read channel, one cycle to the answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
                OFS_ENABLE: s_axi_rdata <= enable_q;
                OFS_PRIO: s_axi_rdata <= prio_q;
                OFS_EXTMODE: s_axi_rdata <= extmode_q;
                OFS_STBY: s_axi_rdata <= {30'h0, state_q};
                OFS_PEND: s_axi_rdata <= {18'h0, pend_q};
                OFS_INSVC: s_axi_rdata <= {29'h0, in_svc_q};
                OFS_EVT_STAT: s_axi_rdata <= {30'h0, evt_stat_q};
                OFS_EVT_CLR: s_axi_rdata <= 32'h0;
                OFS_EVT_EN: s_axi_rdata <= {30'h0, evt_en_q};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // Configuration registers, byte strobes honoured
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= RST_ENABLE;
            prio_q <= RST_PRIO;
            extmode_q <= RST_EXTMODE;
            evt_en_q <= RST_EVT_EN;
        end else if (do_wr) begin
            case (awaddr_q)
                OFS_ENABLE: enable_q <= merge(enable_q, wdata_q, wstrb_q) & 32'h0000_3fff;
                OFS_PRIO: prio_q <= merge(prio_q, wdata_q, wstrb_q) & 32'h0fff_ffff;
                OFS_EXTMODE: extmode_q <= merge(extmode_q, wdata_q, wstrb_q) & 32'h00ff_ffff;
                OFS_EVT_EN: if (wstrb_q[0]) evt_en_q <= wdata_q[1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Pin synchronisers; a change counts once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pin_q <= '0;
            pin_prev_q <= '0;
        end else begin
            s1_q <= {port5_pin, port0_pin, ext_irq_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= (s2_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));
            pin_prev_q <= pin_q;
        end
    end

    // [RULE15] Per-pin detect mode
    for (genvar i = 0; i < N_EXT; i++) begin : g_ext
        always_comb begin
            case (det_mode_e'(extmode_q[3*i+:3]))
                DET_HIGH: ext_det[i] = pin_q[i];
                DET_LOW: ext_det[i] = !pin_q[i];
                DET_RISE: ext_det[i] = pin_q[i] && !pin_prev_q[i];
                DET_FALL: ext_det[i] = !pin_q[i] && pin_prev_q[i];
                DET_BOTH: ext_det[i] = pin_q[i] ^ pin_prev_q[i];
                default: ext_det[i] = 1'b0;
            endcase
        end
    end

    // [RULE16] Port pins fire on a falling edge, low keys pulled up
    assign port_evt = |(~pin_q[N_PIN-1:N_EXT] & pin_prev_q[N_PIN-1:N_EXT]);

    // ==========================================================
    // Request routing onto shared vectors
    always_comb begin
        set_vec = periph_req;
        // [RULE1] [RULE2] Pins 2 and 3 join their shared vectors
        for (int i = 0; i < N_EXT; i++) begin
            if (ext_det[i]) begin
                set_vec[EXT_VEC[i]] = 1'b1;
            end
        end
        // [RULE3] Port events share the last vector
        if (port_evt) begin
            set_vec[PORT_VEC] = 1'b1;
        end
    end

    assign take = irq_req && irq_ack;

    // [RULE17] Pending latch; a new event beats a clear or an accept
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q
                & ~((do_wr && awaddr_q == OFS_PEND) ? wdata_q[N_VEC-1:0] : '0)
                & ~(take ? (N_VEC'(1) << irq_idx_q) : '0)) | set_vec;
        end
    end

    // ==========================================================
    // Arbitration: level first, then lowest address
    assign cand = pend_q & enable_q[N_VEC-1:0];
    assign cur_lvl = in_svc_q[2] ? 2'h3 : in_svc_q[1] ? 2'h2 : in_svc_q[0] ? 2'h1 : 2'h0;

    always_comb begin
        win_valid = 1'b0;
        win_idx = 4'h0;
        win_lvl = 2'h0;
        // [RULE4] [RULE5] [RULE7] Strict compare keeps the lower index on a tie
        for (int v = 0; v < N_VEC; v++) begin
            if (cand[v] && lvl_of(prio_q[2*v+:2]) > win_lvl) begin
                win_valid = 1'b1;
                win_idx = 4'(v);
                win_lvl = lvl_of(prio_q[2*v+:2]);
            end
        end
    end

    // Request to the core, held only while in run state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_req <= 1'b0;
            irq_vector <= VEC_ADDR[0];
            irq_idx_q <= 4'h0;
            irq_lvl_q <= 2'h0;
        end else begin
            // [RULE6] Only a strictly higher level interrupts
            irq_req <= win_valid && (win_lvl > cur_lvl) && (state_q == ST_RUN) && !take;
            irq_vector <= VEC_ADDR[win_idx];
            irq_idx_q <= win_idx;
            irq_lvl_q <= win_lvl;
        end
    end

    // Nesting record; return releases the highest level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_svc_q <= 3'h0;
        end else if (take) begin
            in_svc_q[irq_lvl_q - 2'h1] <= 1'b1;
        end else if (irq_done) begin
            in_svc_q <= in_svc_q & ~(in_svc_q[2] ? 3'h4 : in_svc_q[1] ? 3'h2 : 3'h1);
        end
    end

    // [RULE8] Frame size reported on the cycle after entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_push_bytes <= 4'h0;
        end else begin
            stack_push_bytes <= take ? STACK_FRAME_BYTES : 4'h0;
        end
    end

    // ==========================================================
    // Standby wake conditions; reset pin low is rst_n itself
    // [RULE12] Six full-hold wake sources
    assign wake6 = |(ext_det & EXT_HOLD_WAKE) || port_evt
                || wake_src.sync_serial || wake_src.async_serial;
    // [RULE14] Slow-clock hold adds three more
    assign wake9 = wake6 || wake_src.base_timer || wake_src.ir_rx || wake_src.rtc;
    assign leave = (state_q == ST_HALT && |set_vec) || (state_q == ST_HOLD && wake6)
                || (state_q == ST_HOLD_WITH_SLOW_CLOCK && wake9);

    // Standby state, entered by a write to the standby register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RUN;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (do_wr && awaddr_q == OFS_STBY) begin
                        case (wdata_q[1:0])
                            2'h1: state_q <= ST_HALT;
                            2'h2: state_q <= ST_HOLD;
                            2'h3: state_q <= ST_HOLD_WITH_SLOW_CLOCK;
                            default: state_q <= ST_RUN;
                        endcase
                    end
                end
                // [RULE10] Any request ends halt
                ST_HALT, ST_HOLD, ST_HOLD_WITH_SLOW_CLOCK: if (leave) state_q <= ST_RUN;
                default: state_q <= ST_RUN;
            endcase
        end
    end

    // Stop controls follow the state one cycle later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_ctl <= '0;
        end else begin
            // [RULE9] Halt only stops the core
            stop_ctl.cpu_stop <= state_q != ST_RUN;
            stop_ctl.periph_stop <= state_q == ST_HOLD || state_q == ST_HOLD_WITH_SLOW_CLOCK;
            // [RULE11] [RULE13] Slow crystal survives only slow-clock hold
            stop_ctl.fast_osc_stop <= state_q == ST_HOLD || state_q == ST_HOLD_WITH_SLOW_CLOCK;
            stop_ctl.slow_osc_stop <= state_q == ST_HOLD;
        end
    end

    // ==========================================================
    // Event status, write-one clear, set wins
    assign evt_set = {take, leave};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_stat_q <= 2'h0;
            sys_irq <= 1'b0;
        end else begin
            evt_stat_q <= (evt_stat_q
                & ~((do_wr && awaddr_q == OFS_EVT_CLR) ? wdata_q[1:0] : 2'h0)) | evt_set;
            sys_irq <= |(((evt_stat_q
                & ~((do_wr && awaddr_q == OFS_EVT_CLR) ? wdata_q[1:0] : 2'h0)) | evt_set)
                & evt_en_q);
        end
    end

    // ==========================================================
    // Assertions
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic better;
    always_comb begin
        better = 1'b0;
        for (int j = 0; j < N_VEC; j++) begin
            if (cand[j] && (lvl_of(prio_q[2*j+:2]) > win_lvl
                || (lvl_of(prio_q[2*j+:2]) == win_lvl && 4'(j) < win_idx))) begin
                better = 1'b1;
            end
        end
    end

    property p_pend_set;
        periph_req[0] |=> pend_q[0];
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("request not held pending"); // RULE17
    property p_route_pin2;
        ext_det[2] |=> pend_q[5];
    endproperty
    a_route_pin2: assert property (p_route_pin2) else $error("pin 2 misrouted"); // RULE1
    property p_route_pin3;
        ext_det[3] |=> pend_q[6];
    endproperty
    a_route_pin3: assert property (p_route_pin3) else $error("pin 3 misrouted"); // RULE2
    property p_route_port;
        port_evt |=> pend_q[PORT_VEC];
    endproperty
    a_route_port: assert property (p_route_port) else $error("port event misrouted"); // RULE3
    property p_best_win;
        win_valid |-> !better;
    endproperty
    a_best_win: assert property (p_best_win) else $error("wrong winner"); // RULE5
    property p_nest;
        irq_req |-> irq_lvl_q > cur_lvl;
    endproperty
    a_nest: assert property (p_nest) else $error("request not above current level"); // RULE6
    property p_stack;
        take |=> stack_push_bytes == 4'h6 ##1 stack_push_bytes == 4'h0 || $past(take);
    endproperty
    a_stack: assert property (p_stack) else $error("stack frame size wrong"); // RULE8
    property p_halt_exit;
        state_q == ST_HALT && |set_vec |=> state_q == ST_RUN ##1 !stop_ctl.cpu_stop;
    endproperty
    a_halt_exit: assert property (p_halt_exit) else $error("halt not left"); // RULE10
    property p_hold_stop;
        state_q == ST_HOLD |=> stop_ctl.slow_osc_stop && stop_ctl.fast_osc_stop;
    endproperty
    a_hold_stop: assert property (p_hold_stop) else $error("hold oscillators running"); // RULE11
    property p_hold_with_slow_clock_keep;
        state_q == ST_HOLD_WITH_SLOW_CLOCK |=> !stop_ctl.slow_osc_stop && stop_ctl.periph_stop;
    endproperty
    a_hold_with_slow_clock_keep: assert property (p_hold_with_slow_clock_keep) else $error("slow clock stopped"); // RULE13
    property p_hold_wake;
        state_q == ST_HOLD && !wake6 |=> state_q == ST_HOLD;
    endproperty
    a_hold_wake: assert property (p_hold_wake) else $error("hold left without cause"); // RULE12

    c_take: cover property (take ##[1:20] irq_done);
    c_nested: cover property (take ##[1:50] take);
    c_hold_with_slow_clock_wake: cover property (state_q == ST_HOLD_WITH_SLOW_CLOCK ##1 state_q == ST_RUN);
endmodule // intc_standby_wake
`default_nettype wire

/* File: testbench/core_model.sv */
// Core model that accepts offered interrupt requests
`timescale 1ns/10ps
`default_nettype none
module core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Interrupt link
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic en,
    output logic irq_ack,
    output logic [15:0] taken_vec,
    output logic [7:0] taken_cnt
);
    // ====
    // One-cycle ack; en low stalls the core like a slow handler
    // vector taken on accept
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ack <= 1'b0;
            taken_vec <= 16'h0;
            taken_cnt <= 8'h0;
        end else begin
            irq_ack <= en && irq_req && !irq_ack;
            if (irq_ack && irq_req) begin
                taken_vec <= irq_vector;
                taken_cnt <= taken_cnt + 8'h1;
            end
        end
    end
endmodule // core_model
`default_nettype wire

/* File: testbench/intc_standby_wake_tb.sv */
// Self-checking bench for the interrupt vector and standby wake block
`timescale 1ns/10ps
`default_nettype none
module intc_standby_wake_tb import intc_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awa = '0, ara = '0, tcnt;
    logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, done = 0, en = 0;
    logic [31:0] wd = '0, rdat;
    logic [13:0] preq = '0;
    wake_src_s ws = '0;
    logic [7:0] pin = '0;
    logic [5:0] p0 = '1;
    logic [7:0] p5 = '1;
    logic awr, wrd, bv, arr, rv, ireq, ack, sys;
    logic [1:0] br, rr;
    logic [15:0] ivec, tvec;
    logic [3:0] spb;
    stop_ctl_s stop;
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    // ====
    intc_standby_wake intc_standby_wake_inst (.clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .periph_req(preq), .wake_src(ws),
        .ext_irq_pin(pin), .port0_pin(p0), .port5_pin(p5), .irq_ack(ack),
        .irq_done(done), .irq_req(ireq), .irq_vector(ivec), .stack_push_bytes(spb),
        .stop_ctl(stop), .sys_irq(sys));
    core_model core_model_inst (.clk(clk), .rst_n(rst_n), .irq_req(ireq),
        .irq_vector(ivec), .en(en), .irq_ack(ack), .taken_vec(tvec), .taken_cnt(tcnt));
    always #5 clk = ~clk;
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish;
        end
    end
    // ====
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 0;
        dd = 0;
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        while (!(ad && dd)) begin
            @(posedge clk);
            ad = ad | awr;
            dd = dd | wrd;
            awv <= awv & !awr;
            wv <= wv & !wrd;
        end
        // Ready for the answer only once both halves are taken
        bre <= 1;
        do @(posedge clk); while (!bv);
        bre <= 0;
        chk({30'h0, br}, 32'h0, "write response");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        ara <= a;
        arv <= 1;
        do @(posedge clk); while (!arr);
        arv <= 0;
        rre <= 1;
        do @(posedge clk); while (!rv);
        rre <= 0;
        chk(rdat, e, "read data");
        chk({30'h0, rr}, {30'h0, r}, "read response");
    endtask
    task automatic pulse(input logic [13:0] m, input wake_src_s w);
        preq <= m;
        ws <= w;
        @(posedge clk);
        preq <= '0;
        ws <= '0;
        repeat (3) @(posedge clk);
    endtask
    task automatic ret;
        done <= 1;
        @(posedge clk);
        done <= 0;
        @(posedge clk);
    endtask
    // Let the core accept once, then judge what it got
    task automatic take(input logic [15:0] v);
        logic [7:0] n;
        n = tcnt;
        en <= 1;
        do @(posedge clk); while (tcnt == n);
        en <= 0;
        chk({16'h0, tvec}, {16'h0, v}, "vector");
        chk({28'h0, spb}, 32'h6, "stack bytes");
        chk({31'h0, ireq}, 32'h0, "request dropped");
    endtask
    // ====
    task automatic t_route;
        chk({16'h0, ivec}, 32'h8000, "reset vector");
        rd(OFS_PRIO, 32'h0, 2'h0);
        rd(8'h40, 32'h0, 2'h2);
        wr(OFS_ENABLE, 32'h3fff);
        pulse(14'h0020, '0);
        take(16'h8018);
        ret;
        pulse(14'h0040, '0);
        take(16'h801c);
        ret;
        pulse(14'h2000, '0);
        take(16'h803c);
        ret;
        $display("test routing done");
    endtask
    task automatic t_prio;
        wr(OFS_PRIO, 32'h0400_0000);
        pulse(14'h2040, '0);
        take(16'h803c);
        pulse(14'h2000, '0);
        chk({31'h0, ireq}, 32'h0, "nested refuse");
        rd(OFS_INSVC, 32'h2, 2'h0);
        ret;
        take(16'h803c);
        ret;
        take(16'h801c);
        ret;
        pulse(14'h0060, '0);
        take(16'h8018);
        ret;
        take(16'h801c);
        ret;
        $display("test priority done");
    endtask
    task automatic t_evt;
        wr(OFS_EVT_EN, 32'h2);
        pulse(14'h0020, '0);
        take(16'h8018);
        ret;
        rd(OFS_EVT_STAT, 32'h2, 2'h0);
        chk({31'h0, sys}, 32'h1, "irq raised");
        wr(OFS_EVT_EN, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, sys}, 32'h0, "irq masked");
        wr(OFS_EVT_EN, 32'h2);
        wr(OFS_EVT_CLR, 32'h2);
        repeat (2) @(posedge clk);
        chk({31'h0, sys}, 32'h0, "irq cleared");
        rd(OFS_EVT_STAT, 32'h0, 2'h0);
        $display("test event irq done");
    endtask
    // Halt, full hold, slow-clock hold; foreign events first in full hold only, then a true one in each
    task automatic t_stby;
        logic [3:0] xs [3] = '{4'h8, 4'hf, 4'he};
        wake_src_s bad [3] = '{5'h00, 5'h07, 5'h00};
        wake_src_s good [3] = '{5'h00, 5'h08, 5'h01};
        wr(OFS_ENABLE, 32'h0);
        for (int m = 1; m < 4; m++) begin
            wr(OFS_STBY, 32'(m));
            pulse(14'h0, bad[m-1]);
            chk({28'h0, stop}, {28'h0, xs[m-1]}, "standby stops");
            rd(OFS_STBY, 32'(m), 2'h0);
            pulse(14'(m == 1), good[m-1]);
            chk({28'h0, stop}, 32'h0, "woken stops");
            rd(OFS_STBY, 32'h0, 2'h0);
        end
        $display("test standby done");
    endtask
    task automatic t_pin;
        wr(OFS_PEND, 32'h3fff);
        wr(OFS_ENABLE, 32'h2018);
        // Pin 0 rising, pin 1 both edges, pins 2 and 3 held high on masked vectors
        wr(OFS_EXTMODE, 32'h22);
        pin <= 8'h0d;
        take(16'h800c);
        ret;
        pin[1] <= 1;
        take(16'h8014);
        ret;
        pin[1] <= 0;
        take(16'h8014);
        ret;
        p0[0] <= 0;
        take(16'h803c);
        ret;
        p5[7] <= 0;
        take(16'h803c);
        ret;
        $display("test pins done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        t_route;
        t_prio;
        t_evt;
        t_stby;
        t_pin;
        tally_and_finish;
    end
endmodule // intc_standby_wake_tb
`default_nettype wire
